// file: hdl/fas_top.sv
// Fault and alarm supervision with status indicators and an AXI4-Lite register slave.
//
// Function
// - Active faults apply configured stop reaction.
// - Encoder fault reaction always coasts motor down.
// - Power-cycle faults stay latched until reset.
// - Immediate faults clear once cause vanishes.
// - Pulse-inhibit faults acknowledge only while inhibited.
// - Display marks entry single, first, or later.
// - Faults hide alarms until all acknowledged.
// - Acknowledged persisting fault returns after idle.
// - PC tool acknowledge acts like panel acknowledge.
// - Two dual-colour indicators: drive and link.
// - Drive indicator steady green when servo on.
// - Drive indicator steady red when servo off.
// - Drive indicator flashes red 1 Hz on events.
// - Locate alternates red and orange every 0.5s.
// - Link indicator dark without PC session.
// - Link indicator flashes green 0.5 Hz in session.
// - Link indicator flashes green 2 Hz card busy.
// - Link indicator steady red on link error.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module fas_top #(
   parameter int N = 8,
   parameter int unsigned LED_TICK_CYC = fas_pkg::LED_TICK_CYC,
   parameter int unsigned RETRY_IDLE_CYC = fas_pkg::RETRY_IDLE_CYC
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Event causes from drive logic
   input wire logic [N-1:0] fault_cause,
   input wire logic [N-1:0] alarm_cause,
   input wire logic pulses_inhibited,
   // Operator panel and reset digital input
   input wire logic operator_panel_key,
   input wire logic operator_panel_ack,
   input wire logic reset_di,
   // Stop reactions
   output logic ramp_stop,
   output logic coast_stop,
   output logic quick_stop,
   // Display
   output logic disp_valid,
   output logic disp_is_fault,
   output logic [$clog2(N)-1:0] disp_index,
   output logic [1:0] disp_pos,
   // Indicators
   output logic drive_led_green,
   output logic drive_led_red,
   output logic link_activity_indicator_green,
   output logic link_activity_indicator_red
);

   localparam int IW = $clog2(N);

   // ----------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------
   function automatic logic [IW-1:0] lowest_set(input logic [N-1:0] v);
      logic [IW-1:0] r;
      r = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = IW'(i);
         end
      end
      return r;
   endfunction : lowest_set

   function automatic logic [IW-1:0] next_set(input logic [N-1:0] v, input logic [IW-1:0] from);
      logic [IW-1:0] r;
      logic found;
      r = lowest_set(v);
      found = 1'b0;
      for (int i = 0; i < N; i++) begin
         if (!found && v[i] && IW'(i) > from) begin
            r = IW'(i);
            found = 1'b1;
         end
      end
      return r;
   endfunction : next_set

   function automatic logic more_than_one(input logic [N-1:0] v);
      return (v & (v - N'(1))) != '0;
   endfunction : more_than_one

   // ----------------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------------
   logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
   logic [11:0] awaddr_r;
   logic [31:0] wdata_r, rdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r, rresp_r;
   logic do_write;
   logic [4:0] ctrl_r;
   logic [5:0] cfg_r [N];
   logic pc_ack, disp_next;

   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign do_write = aw_held_r && w_held_r && !bvalid_r;

   function automatic logic cfg_hit(input logic [11:0] a);
      return a[11:2] >= fas_pkg::OFS_CFG_BASE[11:2] && a[11:2] < fas_pkg::OFS_CFG_BASE[11:2] + 10'(N);
   endfunction : cfg_hit

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= fas_pkg::RESP_OKAY;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= (awaddr_r[11:2] == fas_pkg::OFS_CTRL[11:2] || awaddr_r[11:2] == fas_pkg::OFS_CMD[11:2]
                        || cfg_hit(awaddr_r)) ? fas_pkg::RESP_OKAY : fas_pkg::RESP_SLVERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Command bits are one-cycle pulses produced by a write; they never store.
   assign pc_ack = do_write && awaddr_r[11:2] == fas_pkg::OFS_CMD[11:2] && wstrb_r[0]
                   && wdata_r[fas_pkg::CMD_PC_ACK];
   assign disp_next = do_write && awaddr_r[11:2] == fas_pkg::OFS_CMD[11:2] && wstrb_r[0]
                      && wdata_r[fas_pkg::CMD_DISP_NEXT];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= fas_pkg::CTRL_RESET;
      end else if (do_write && awaddr_r[11:2] == fas_pkg::OFS_CTRL[11:2] && wstrb_r[0]) begin
         ctrl_r <= wdata_r[4:0];
      end
   end

   always_ff @(posedge aclk) begin
      for (int i = 0; i < N; i++) begin
         if (!aresetn) begin
            cfg_r[i] <= fas_pkg::CFG_RESET;
         end else if (do_write && cfg_hit(awaddr_r) && wstrb_r[0]
                      && awaddr_r[11:2] - fas_pkg::OFS_CFG_BASE[11:2] == 10'(i)) begin
            cfg_r[i] <= wdata_r[5:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Acknowledge sources
   // ----------------------------------------------------------------------
   logic rst_sync1_r, rst_sync2_r, rst_prev_r, ack_pulse;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rst_sync1_r <= 1'b0;
         rst_sync2_r <= 1'b0;
         rst_prev_r <= 1'b0;
      end else begin
         rst_sync1_r <= reset_di;
         rst_sync2_r <= rst_sync1_r;
         rst_prev_r <= rst_sync2_r;
      end
   end

   assign ack_pulse = operator_panel_ack || (rst_sync2_r && !rst_prev_r) || pc_ack;

   // ----------------------------------------------------------------------
   // Fault and alarm latches
   // ----------------------------------------------------------------------
   logic [N-1:0] fault_act_r, hidden_r, alarm_act_r, ackable, auto_clr;
   logic [31:0] idle_cnt_r;
   logic idle_done;

   always_comb begin
      for (int i = 0; i < N; i++) begin
         ackable[i] = cfg_r[i][5:4] == fas_pkg::ACK_IMMED
                      || (cfg_r[i][5:4] == fas_pkg::ACK_PINH && pulses_inhibited);
         auto_clr[i] = cfg_r[i][5:4] == fas_pkg::ACK_IMMED && !fault_cause[i];
      end
   end

   // Idle time restarts on any key or acknowledge and saturates at the retry time.
   always_ff @(posedge aclk) begin
      if (!aresetn || operator_panel_key || ack_pulse) begin
         idle_cnt_r <= '0;
      end else if (idle_cnt_r != RETRY_IDLE_CYC) begin
         idle_cnt_r <= idle_cnt_r + 32'h1;
      end
   end
   assign idle_done = idle_cnt_r == RETRY_IDLE_CYC;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hidden_r <= '0;
      end else begin
         // An acknowledge in the cycle in which the idle time runs out does not keep a hidden fault hidden; it only hides active faults.
         hidden_r <= ((hidden_r & ~{N{idle_done}}) | ({N{ack_pulse}} & ackable & fault_act_r & fault_cause))
                     & fault_cause;
      end
   end

   // A present cause wins over the automatic clear but not over an acknowledge; power-cycle faults only leave through reset.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_act_r <= '0;
      end else begin
         fault_act_r <= (fault_cause & ~hidden_r & ~({N{ack_pulse}} & ackable & fault_act_r))
                        | (fault_act_r & ~auto_clr & ~({N{ack_pulse}} & ackable));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         alarm_act_r <= '0;
      end else begin
         alarm_act_r <= alarm_cause;
      end
   end

   // ----------------------------------------------------------------------
   // Reactions
   // ----------------------------------------------------------------------
   logic [N-1:0] rx_ramp, rx_coast, rx_quick;

   always_comb begin
      for (int i = 0; i < N; i++) begin
         rx_ramp[i] = fault_act_r[i] && cfg_r[i][2:0] == fas_pkg::RX_RAMP;
         rx_coast[i] = fault_act_r[i] && (cfg_r[i][2:0] == fas_pkg::RX_COAST
                       || cfg_r[i][2:0] == fas_pkg::RX_ENCODER);
         rx_quick[i] = fault_act_r[i] && cfg_r[i][2:0] == fas_pkg::RX_QUICK;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ramp_stop <= 1'b0;
         coast_stop <= 1'b0;
         quick_stop <= 1'b0;
      end else begin
         ramp_stop <= |rx_ramp;
         coast_stop <= |rx_coast;
         quick_stop <= |rx_quick;
      end
   end

   // ----------------------------------------------------------------------
   // Display selection
   // ----------------------------------------------------------------------
   logic [N-1:0] shown;
   logic [IW-1:0] sel_r, cur;

   assign shown = (|fault_act_r) ? fault_act_r : alarm_act_r;
   assign cur = shown[sel_r] ? sel_r : lowest_set(shown);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_r <= '0;
      end else if (disp_next || !shown[sel_r]) begin
         sel_r <= disp_next ? next_set(shown, cur) : lowest_set(shown);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         disp_valid <= 1'b0;
         disp_is_fault <= 1'b0;
         disp_index <= '0;
         disp_pos <= fas_pkg::POS_SINGLE;
      end else begin
         disp_valid <= |shown;
         disp_is_fault <= |fault_act_r;
         disp_index <= cur;
         disp_pos <= !more_than_one(shown) ? fas_pkg::POS_SINGLE
                     : (cur == lowest_set(shown)) ? fas_pkg::POS_FIRST : fas_pkg::POS_LATER;
      end
   end

   // ----------------------------------------------------------------------
   // Indicators
   // ----------------------------------------------------------------------
   logic [31:0] tick_cnt_r;
   logic [2:0] phase_r;
   logic pending;

   // Phase bit 0 toggles every 0.25 s (2 Hz), bit 1 every 0.5 s (1 Hz), bit 2 every 1 s (0.5 Hz).
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt_r <= '0;
         phase_r <= '0;
      end else if (tick_cnt_r == LED_TICK_CYC - 1) begin
         tick_cnt_r <= '0;
         phase_r <= phase_r + 3'h1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h1;
      end
   end

   assign pending = (|fault_act_r) || (|alarm_act_r);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drive_led_green <= 1'b0;
         drive_led_red <= 1'b1;
      end else if (ctrl_r[fas_pkg::CTRL_LOCATE]) begin
         drive_led_green <= phase_r[1];
         drive_led_red <= 1'b1;
      end else if (pending) begin
         drive_led_green <= 1'b0;
         drive_led_red <= phase_r[1];
      end else if (ctrl_r[fas_pkg::CTRL_SERVO_ON]) begin
         drive_led_green <= 1'b1;
         drive_led_red <= 1'b0;
      end else begin
         drive_led_green <= 1'b0;
         drive_led_red <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         link_activity_indicator_green <= 1'b0;
         link_activity_indicator_red <= 1'b0;
      end else if (ctrl_r[fas_pkg::CTRL_PC_ERROR]) begin
         link_activity_indicator_green <= 1'b0;
         link_activity_indicator_red <= 1'b1;
      end else if (ctrl_r[fas_pkg::CTRL_CARD_BUSY]) begin
         link_activity_indicator_green <= phase_r[0];
         link_activity_indicator_red <= 1'b0;
      end else if (ctrl_r[fas_pkg::CTRL_PC_SESSION]) begin
         link_activity_indicator_green <= phase_r[2];
         link_activity_indicator_red <= 1'b0;
      end else begin
         link_activity_indicator_green <= 1'b0;
         link_activity_indicator_red <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Register read
   // ----------------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= fas_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rresp_r <= fas_pkg::RESP_OKAY;
         rdata_r <= '0;
         unique case (s_axi_araddr[11:2])
            fas_pkg::OFS_CTRL[11:2]: rdata_r <= 32'(ctrl_r);
            fas_pkg::OFS_CMD[11:2]: rdata_r <= '0;
            fas_pkg::OFS_FAULT_PEND[11:2]: rdata_r <= 32'(fault_act_r);
            fas_pkg::OFS_ALARM_PEND[11:2]: rdata_r <= 32'(alarm_act_r);
            fas_pkg::OFS_DISPLAY[11:2]: rdata_r <= {16'h0000, disp_valid, 1'b0, disp_pos, 3'h0, disp_is_fault,
                                                    8'(disp_index)};
            fas_pkg::OFS_REACT[11:2]: rdata_r <= {29'h0, quick_stop, coast_stop, ramp_stop};
            fas_pkg::OFS_LED[11:2]: rdata_r <= {28'h0, link_activity_indicator_red, link_activity_indicator_green,
                                                drive_led_red, drive_led_green};
            default: begin
               if (cfg_hit(s_axi_araddr)) begin
                  rdata_r <= 32'(cfg_r[IW'(s_axi_araddr[11:2] - fas_pkg::OFS_CFG_BASE[11:2])]);
               end else begin
                  rresp_r <= fas_pkg::RESP_SLVERR;
               end
            end
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   a_coast_reaction: assert property (@(posedge aclk) disable iff (!aresetn) (|rx_coast) |=> coast_stop)
      else $error("coast reaction missing");
   a_power_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (|(fault_act_r & ~ackable & ~auto_clr)) |=> (|fault_act_r))
      else $error("latched fault dropped");
   a_alarm_follow: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 alarm_act_r == $past(alarm_cause))
      else $error("alarm does not follow cause");
   a_fault_first: assert property (@(posedge aclk) disable iff (!aresetn)
      (|fault_act_r) |=> disp_valid && disp_is_fault)
      else $error("alarm shown over fault");
   a_single_pos: assert property (@(posedge aclk) disable iff (!aresetn)
      ($onehot(shown)) |=> disp_pos == fas_pkg::POS_SINGLE)
      else $error("single entry mislabelled");
   a_servo_green: assert property (@(posedge aclk) disable iff (!aresetn)
      (ctrl_r[fas_pkg::CTRL_SERVO_ON] && !pending && !ctrl_r[fas_pkg::CTRL_LOCATE])
      |=> drive_led_green && !drive_led_red)
      else $error("servo on not green");
   a_event_flash: assert property (@(posedge aclk) disable iff (!aresetn)
      (pending && !ctrl_r[fas_pkg::CTRL_LOCATE]) |=> !drive_led_green && drive_led_red == $past(phase_r[1]))
      else $error("event flash wrong");
   a_link_dark: assert property (@(posedge aclk) disable iff (!aresetn)
      (ctrl_r[4:2] == 3'h0) |=> !link_activity_indicator_green && !link_activity_indicator_red)
      else $error("link indicator lit");
   a_link_error: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_r[fas_pkg::CTRL_PC_ERROR] |=> link_activity_indicator_red && !link_activity_indicator_green)
      else $error("link error not red");
   a_retry_raise: assert property (@(posedge aclk) disable iff (!aresetn)
      (idle_done && |(fault_cause & hidden_r)) ##1 (|(fault_cause & $past(fault_cause & hidden_r)))
      |=> (|fault_act_r))
      else $error("fault not raised again");

endmodule : fas_top

`default_nettype wire

// file: hdl/fas_pkg.sv
// Constants shared by the fault, alarm and status indicator block.
package fas_pkg;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned LED_TICK_MS = 250;
   localparam int unsigned LED_TICK_CYC = LED_TICK_MS * 1000000 / CLK_PERIOD_NS;
   localparam longint unsigned RETRY_IDLE_MS = 5000;
   localparam int unsigned RETRY_IDLE_CYC = 32'(RETRY_IDLE_MS * 1000000 / CLK_PERIOD_NS);

   // ----------------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_CMD = 12'h004;
   localparam logic [11:0] OFS_FAULT_PEND = 12'h008;
   localparam logic [11:0] OFS_ALARM_PEND = 12'h00C;
   localparam logic [11:0] OFS_DISPLAY = 12'h010;
   localparam logic [11:0] OFS_REACT = 12'h014;
   localparam logic [11:0] OFS_LED = 12'h018;
   localparam logic [11:0] OFS_CFG_BASE = 12'h040;

   // ----------------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------------
   localparam int CTRL_SERVO_ON = 0;
   localparam int CTRL_LOCATE = 1;
   localparam int CTRL_PC_SESSION = 2;
   localparam int CTRL_PC_ERROR = 3;
   localparam int CTRL_CARD_BUSY = 4;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   localparam int CMD_PC_ACK = 0;
   localparam int CMD_DISP_NEXT = 1;
   localparam int CFG_RX_LSB = 0;
   localparam int CFG_ACK_LSB = 4;
   localparam logic [5:0] CFG_RESET = 6'h12;

   // ----------------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------------
   localparam logic [2:0] RX_NONE = 3'h0;
   localparam logic [2:0] RX_RAMP = 3'h1;
   localparam logic [2:0] RX_COAST = 3'h2;
   localparam logic [2:0] RX_QUICK = 3'h3;
   localparam logic [2:0] RX_ENCODER = 3'h4;
   localparam logic [1:0] ACK_POWER = 2'h0;
   localparam logic [1:0] ACK_IMMED = 2'h1;
   localparam logic [1:0] ACK_PINH = 2'h2;
   localparam logic [1:0] POS_SINGLE = 2'h0;
   localparam logic [1:0] POS_FIRST = 2'h1;
   localparam logic [1:0] POS_LATER = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : fas_pkg

// file: testbench/fas_panel.sv
// Model of the operator panel keys and the reset digital input.
`timescale 1ns/1ns
`default_nettype none
module fas_panel (
   // Commands from the bench
   input wire logic aclk,
   input wire logic do_key,
   input wire logic do_ack,
   input wire logic do_rst,
   // Pins towards the drive
   output var logic operator_panel_key = 1'h0,
   output var logic operator_panel_ack = 1'h0,
   output var logic reset_di = 1'h0
);
   logic [1:0] hold = 2'h0;
   always @(posedge aclk) begin
      operator_panel_ack <= do_ack;
      operator_panel_key <= do_key | do_ack;
      hold <= do_rst ? 2'h3 : hold - {1'h0, hold != 2'h0};
      reset_di <= do_rst | (hold != 2'h0);
   end
endmodule : fas_panel
`default_nettype wire

// file: testbench/fas_top_bench.sv
// Self-checking bench for the fault, alarm and indicator block.
`timescale 1ns/1ns
`default_nettype none
module fas_top_bench;
   localparam int TK = 4;
   logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
   logic rready = 1'h0, pinh = 1'h0, do_key = 1'h0, do_ack = 1'h0, do_rst = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, key, ack, rdi, ramp, coast, quick, dv, dfault;
   logic dg, dr, lg, lr;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = '0, rdata, rd;
   logic [7:0] fcause = '0, acause = '0;
   logic [1:0] bresp, rresp, resp, dpos;
   logic [2:0] didx;
   int mismatches = 0, samples_checked = 0;
   always #2 aclk = ~aclk;
   fas_top #(.N(8), .LED_TICK_CYC(TK), .RETRY_IDLE_CYC(20)) u_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .fault_cause(fcause), .alarm_cause(acause), .pulses_inhibited(pinh),
      .operator_panel_key(key), .operator_panel_ack(ack), .reset_di(rdi), .ramp_stop(ramp),
      .coast_stop(coast), .quick_stop(quick), .disp_valid(dv), .disp_is_fault(dfault), .disp_index(didx),
      .disp_pos(dpos), .drive_led_green(dg), .drive_led_red(dr), .link_activity_indicator_green(lg),
      .link_activity_indicator_red(lr));
   fas_panel u_panel (.aclk(aclk), .do_key(do_key), .do_ack(do_ack), .do_rst(do_rst),
      .operator_panel_key(key), .operator_panel_ack(ack), .reset_di(rdi));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic ta, tw, b;
      ta = 1'h0;
      tw = 1'h0;
      b = 1'h0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while (!(ta && tw)) begin
         @(negedge aclk);
         ta = ta | (awvalid & awready);
         tw = tw | (wvalid & wready);
         @(posedge aclk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
      end
      bready <= 1'h1;
      while (b !== 1'h1) begin
         @(negedge aclk);
         b = bvalid;
         resp = bresp;
         @(posedge aclk);
      end
      bready <= 1'h0;
   endtask : wr
   task automatic rdr(input logic [11:0] a);
      logic t;
      t = 1'h0;
      araddr <= a;
      arvalid <= 1'h1;
      while (t !== 1'h1) begin
         @(negedge aclk);
         t = arready;
         @(posedge aclk);
      end
      arvalid <= 1'h0;
      rready <= 1'h1;
      t = 1'h0;
      while (t !== 1'h1) begin
         @(negedge aclk);
         t = rvalid;
         rd = rdata;
         resp = rresp;
         @(posedge aclk);
      end
      rready <= 1'h0;
   endtask : rdr
   // Counts rising edges of one indicator line over 64 cycles.
   task automatic flash(input int sel, input int exp);
      int n;
      logic p;
      logic [3:0] v;
      n = 0;
      @(negedge aclk);
      v = {lr, lg, dr, dg};
      p = v[sel];
      repeat (64) begin
         @(negedge aclk);
         v = {lr, lg, dr, dg};
         if (v[sel] === 1'h1 && p === 1'h0) n++;
         p = v[sel];
      end
      check(n, exp);
      @(posedge aclk);
   endtask : flash
   function automatic int rises(input int hz_x2);
      return 64 * hz_x2 / (8 * TK);
   endfunction : rises
   function automatic logic [31:0] react_of(input logic [2:0] r);
      case (r)
         fas_pkg::RX_RAMP: return 32'h1;
         fas_pkg::RX_COAST, fas_pkg::RX_ENCODER: return 32'h2;
         fas_pkg::RX_QUICK: return 32'h4;
         default: return 32'h0;
      endcase
   endfunction : react_of
   task automatic wrap_up;
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      wrap_up();
   end
   initial begin
      int i;
      void'($urandom(32'h39AB37BF));
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      check({dr, dg, lr, lg}, 32'h8);
      rdr(12'h030);
      check(resp, fas_pkg::RESP_SLVERR);
      for (int r = 0; r < 5; r++) begin
         i = 1 + $urandom % 7;
         wr(fas_pkg::OFS_CFG_BASE + 12'(4 * i), 32'h10 | r);
         fcause[i] <= 1'h1;
         repeat (4) @(posedge aclk);
         check({quick, coast, ramp}, react_of(3'(r)));
         fcause[i] <= 1'h0;
         repeat (4) @(posedge aclk);
         rdr(fas_pkg::OFS_FAULT_PEND);
         check(rd, 32'h0);
      end
      acause <= 8'h06;
      repeat (4) @(posedge aclk);
      check({dv, dfault, dpos, quick, coast, ramp}, {1'h1, 1'h0, fas_pkg::POS_FIRST, 3'h0});
      wr(fas_pkg::OFS_CMD, 32'h2);
      repeat (2) @(posedge aclk);
      check({didx, dpos}, {3'h2, fas_pkg::POS_LATER});
      flash(1, rises(2));
      fcause[0] <= 1'h1;
      repeat (4) @(posedge aclk);
      check({dv, dfault, dpos}, {1'h1, 1'h1, fas_pkg::POS_SINGLE});
      fcause[0] <= 1'h0;
      repeat (4) @(posedge aclk);
      check(dfault, 32'h0);
      acause <= 8'h00;
      fcause[0] <= 1'h1;
      repeat (4) @(posedge aclk);
      wr(fas_pkg::OFS_CMD, 32'h1);
      rdr(fas_pkg::OFS_FAULT_PEND);
      check(rd, 32'h0);
      do_key <= 1'h1;
      @(posedge aclk);
      do_key <= 1'h0;
      repeat (19) @(posedge aclk);
      rdr(fas_pkg::OFS_FAULT_PEND);
      check(rd, 32'h0);
      repeat (30) @(posedge aclk);
      rdr(fas_pkg::OFS_FAULT_PEND);
      check(rd, 32'h1);
      fcause[0] <= 1'h0;
      wr(fas_pkg::OFS_CFG_BASE + 12'h008, 32'h21);
      fcause[2] <= 1'h1;
      repeat (4) @(posedge aclk);
      fcause[2] <= 1'h0;
      for (int k = 0; k < 2; k++) begin
         pinh <= 1'(k);
         do_rst <= 1'h1;
         @(posedge aclk);
         do_rst <= 1'h0;
         repeat (10) @(posedge aclk);
         rdr(fas_pkg::OFS_FAULT_PEND);
         check(rd, k ? 32'h0 : 32'h4);
      end
      wr(fas_pkg::OFS_CFG_BASE + 12'h00C, 32'h03);
      fcause[3] <= 1'h1;
      do_ack <= 1'h1;
      @(posedge aclk);
      do_ack <= 1'h0;
      fcause[3] <= 1'h0;
      repeat (10) @(posedge aclk);
      rdr(fas_pkg::OFS_FAULT_PEND);
      check(rd, 32'h8);
      aresetn <= 1'h0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      rdr(fas_pkg::OFS_FAULT_PEND);
      check(rd, 32'h0);
      wr(fas_pkg::OFS_CTRL, 32'h1);
      repeat (2) @(posedge aclk);
      check({dr, dg}, 32'h1);
      wr(fas_pkg::OFS_CTRL, 32'h3);
      flash(0, rises(2));
      flash(1, 0);
      wr(fas_pkg::OFS_CTRL, 32'h4);
      flash(2, rises(1));
      wr(fas_pkg::OFS_CTRL, 32'h14);
      flash(2, rises(4));
      wr(fas_pkg::OFS_CTRL, 32'h1C);
      repeat (2) @(posedge aclk);
      check({lr, lg}, 32'h2);
      wrap_up();
   end
endmodule : fas_top_bench
`default_nettype wire
